// ==== dsd_params.svh ====
// constants for the dual converter serial word decoder
`ifndef DSD_PARAMS_SVH
`define DSD_PARAMS_SVH

// ****************************************************************
// word layout
// ****************************************************************
`define DSD_WORD_BITS 16
`define DSD_PAYLOAD_BITS 12
`define DSD_VALUE_BITS 10
`define DSD_REF_BITS 2
`define DSD_BIT_SEL_HIGH 15
`define DSD_BIT_FAST 14
`define DSD_BIT_PWR 13
`define DSD_BIT_SEL_LOW 12
`define DSD_VALUE_MSB 11
`define DSD_VALUE_LSB 2
`define DSD_REF_MSB 1
`define DSD_REF_LSB 0

// ****************************************************************
// target select codes {high, low}
// ****************************************************************
`define DSD_SEL_B_AND_BUF 2'h0
`define DSD_SEL_BUF_ONLY 2'h1
`define DSD_SEL_A_AND_B_FROM_BUF 2'h2
`define DSD_SEL_CONTROL 2'h3

// ****************************************************************
// reference field codes
// ****************************************************************
`define DSD_REF_EXTERNAL_LO 2'h0
`define DSD_REF_INT_1V024 2'h1
`define DSD_REF_INT_2V048 2'h2
`define DSD_REF_EXTERNAL_HI 2'h3

// ****************************************************************
// reset values and bit counting
// ****************************************************************
`define DSD_VALUE_RESET 10'h000
`define DSD_REF_RESET 2'h0
`define DSD_WORD_RESET 16'h0000
`define DSD_CNT_BITS 5
`define DSD_CNT_ZERO 5'h00
`define DSD_CNT_ONE 5'h01
`define DSD_CNT_LAST 5'h0F
`define DSD_CNT_FULL 5'h10

`endif

// ==== dsd_pkg.sv ====
// types shared by the serial word decoder files
`default_nettype none
`include "dsd_params.svh"

package dsd_pkg;

  // ****************************************************************
  // command word as shifted in, msb first
  // ****************************************************************
  typedef struct packed {
    logic target_select_high;
    logic fast_settle_select;
    logic power_down_request;
    logic target_select_low;
    logic [`DSD_PAYLOAD_BITS-1:0] payload;
  } dsd_word_t;

  // ****************************************************************
  // settings that the converter core sees
  // ****************************************************************
  typedef struct packed {
    logic fast_settle_select;
    logic power_down_request;
    logic reference_select_high;
    logic reference_select_low;
  } dsd_ctrl_t;

  typedef enum logic [2:0] {
    DSD_ST_IDLE = 3'b001,
    DSD_ST_CAPTURE = 3'b010,
    DSD_ST_APPLY = 3'b100
  } dsd_state_t;

endpackage

`default_nettype wire

// ==== dsd_sync2.sv ====
// two-flop level synchroniser into the core clock domain
`timescale 1ns/100ps
`default_nettype none

module dsd_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // dsd_sync2

`default_nettype wire

// ==== dsd_word_decoder.sv ====
// serial command word decoder for a dual 10-bit converter
`timescale 1ns/100ps
`default_nettype none
`include "dsd_params.svh"


module dsd_word_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdin,
  output logic [`DSD_VALUE_BITS-1:0] channel_a_value,
  output logic [`DSD_VALUE_BITS-1:0] channel_b_value,
  output logic [`DSD_VALUE_BITS-1:0] holding_value,
  output logic fast_settle_select,
  output logic power_down_request,
  output logic reference_select_high,
  output logic reference_select_low,
  output logic internal_reference_enable,
  output logic internal_reference_2v048,
  output logic word_applied
);

  // ****************************************************************
  // link domain: shift register on falling sclk
  // ****************************************************************
  logic link_clear;
  logic [`DSD_CNT_BITS-1:0] bit_count;
  logic [`DSD_CNT_BITS-1:0] next_bit_count;
  logic [`DSD_WORD_BITS-1:0] shift_word;
  logic [`DSD_WORD_BITS-1:0] next_shift_word;
  logic [`DSD_WORD_BITS-1:0] full_word;
  logic [`DSD_WORD_BITS-1:0] next_full_word;
  logic full_toggle;
  logic next_full_toggle;
  logic partial_pending;
  logic next_partial_pending;
  logic frame_toggle;
  logic next_frame_toggle;

  // chip select high clears the count so the next fall starts fresh
  assign link_clear = rst | cs_n;

  always_comb begin
    next_bit_count = bit_count;
    if (bit_count != `DSD_CNT_FULL) begin
      next_bit_count = bit_count + `DSD_CNT_ONE;
    end
  end

  always_ff @(negedge sclk or posedge link_clear) begin
    if (link_clear) begin
      bit_count <= `DSD_CNT_ZERO;
    end else begin
      bit_count <= next_bit_count;
    end
  end

  always_comb begin
    next_shift_word = shift_word;
    next_full_word = full_word;
    next_full_toggle = full_toggle;
    next_partial_pending = partial_pending;
    next_frame_toggle = frame_toggle;
    // bits past the sixteenth are dropped, the word is already gone
    if (!cs_n && bit_count != `DSD_CNT_FULL) begin
      next_shift_word = {shift_word[`DSD_WORD_BITS-2:0], sdin};
      next_partial_pending = 1'b1;
      // marks a new frame so a bare chip select pulse cannot replay a short word
      if (bit_count == `DSD_CNT_ZERO) begin
        next_frame_toggle = ~frame_toggle;
      end
      if (bit_count == `DSD_CNT_LAST) begin
        next_full_word = {shift_word[`DSD_WORD_BITS-2:0], sdin};
        next_full_toggle = ~full_toggle;
        next_partial_pending = 1'b0;
      end
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      shift_word <= `DSD_WORD_RESET;
      full_word <= `DSD_WORD_RESET;
      full_toggle <= 1'b0;
      partial_pending <= 1'b0;
      frame_toggle <= 1'b0;
    end else begin
      shift_word <= next_shift_word;
      full_word <= next_full_word;
      full_toggle <= next_full_toggle;
      partial_pending <= next_partial_pending;
      frame_toggle <= next_frame_toggle;
    end
  end

  // ****************************************************************
  // crossings into the core domain
  // ****************************************************************
  logic full_toggle_sync;
  logic full_toggle_seen;
  logic partial_pending_sync;
  logic frame_toggle_sync;
  logic frame_used;
  logic next_frame_used;
  logic cs_n_sync;
  logic cs_n_seen;
  logic full_event;
  logic cs_rise_event;

  dsd_sync2 #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_sync_full (
    .clk(clk),
    .rst(rst),
    .async_in(full_toggle),
    .sync_out(full_toggle_sync)
  );

  dsd_sync2 #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_sync_partial (
    .clk(clk),
    .rst(rst),
    .async_in(partial_pending),
    .sync_out(partial_pending_sync)
  );

  dsd_sync2 #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_sync_frame (
    .clk(clk),
    .rst(rst),
    .async_in(frame_toggle),
    .sync_out(frame_toggle_sync)
  );

  dsd_sync2 #(
    .WIDTH(1),
    .RESET_VALUE(1'b1)
  ) u_sync_cs (
    .clk(clk),
    .rst(rst),
    .async_in(cs_n),
    .sync_out(cs_n_sync)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      full_toggle_seen <= 1'b0;
      cs_n_seen <= 1'b1; // idle level, so no false rise after reset
    end else begin
      full_toggle_seen <= full_toggle_sync;
      cs_n_seen <= cs_n_sync;
    end
  end

  assign full_event = full_toggle_sync ^ full_toggle_seen;
  // an early rise only counts when a short word of an unused frame is waiting
  assign cs_rise_event = cs_n_sync & ~cs_n_seen & partial_pending_sync & (frame_toggle_sync ^ frame_used);

  // ****************************************************************
  // core domain: capture and apply the word
  // ****************************************************************
  dsd_pkg::dsd_state_t state;
  dsd_pkg::dsd_state_t next_state;
  dsd_pkg::dsd_word_t cmd;
  dsd_pkg::dsd_word_t next_cmd;
  dsd_pkg::dsd_ctrl_t ctrl;
  dsd_pkg::dsd_ctrl_t next_ctrl;
  logic [`DSD_VALUE_BITS-1:0] next_channel_a_value;
  logic [`DSD_VALUE_BITS-1:0] next_channel_b_value;
  logic [`DSD_VALUE_BITS-1:0] next_holding_value;
  logic next_internal_reference_enable;
  logic next_internal_reference_2v048;
  logic next_word_applied;
  logic [1:0] target;
  logic [`DSD_VALUE_BITS-1:0] cmd_value;
  logic [`DSD_REF_BITS-1:0] cmd_ref;
  logic [`DSD_REF_BITS-1:0] new_ref;

  assign target = {cmd.target_select_high, cmd.target_select_low};
  assign cmd_value = cmd.payload[`DSD_VALUE_MSB:`DSD_VALUE_LSB];
  assign cmd_ref = cmd.payload[`DSD_REF_MSB:`DSD_REF_LSB];

  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_ctrl = ctrl;
    next_channel_a_value = channel_a_value;
    next_channel_b_value = channel_b_value;
    next_holding_value = holding_value;
    next_word_applied = 1'b0;
    next_frame_used = frame_used;
    case (state)
      dsd_pkg::DSD_ST_IDLE: begin
        if (full_event || cs_rise_event) begin
          next_state = dsd_pkg::DSD_ST_CAPTURE;
          next_frame_used = frame_toggle_sync;
        end
      end
      dsd_pkg::DSD_ST_CAPTURE: begin
        // sources are quiet here: full word held, or sclk stopped
        if (partial_pending_sync && cs_n_sync) begin
          next_cmd = dsd_pkg::dsd_word_t'(shift_word);
        end else begin
          next_cmd = dsd_pkg::dsd_word_t'(full_word);
        end
        next_state = dsd_pkg::DSD_ST_APPLY;
      end
      dsd_pkg::DSD_ST_APPLY: begin
        next_ctrl.fast_settle_select = cmd.fast_settle_select;
        next_ctrl.power_down_request = cmd.power_down_request;
        case (target)
          `DSD_SEL_B_AND_BUF: begin
            next_channel_b_value = cmd_value;
            next_holding_value = cmd_value;
          end
          `DSD_SEL_BUF_ONLY: begin
            next_holding_value = cmd_value;
          end
          `DSD_SEL_A_AND_B_FROM_BUF: begin
            next_channel_a_value = cmd_value;
            next_channel_b_value = holding_value;
          end
          `DSD_SEL_CONTROL: begin
            next_ctrl.reference_select_high = cmd_ref[1];
            next_ctrl.reference_select_low = cmd_ref[0];
          end
          default: begin
            next_holding_value = holding_value;
          end
        endcase
        next_word_applied = 1'b1;
        next_state = dsd_pkg::DSD_ST_IDLE;
      end
      default: begin
        next_state = dsd_pkg::DSD_ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // reference decode, registered with the field
  // ****************************************************************
  always_comb begin
    new_ref = {next_ctrl.reference_select_high, next_ctrl.reference_select_low};
    next_internal_reference_enable = 1'b0;
    next_internal_reference_2v048 = 1'b0;
    case (new_ref)
      `DSD_REF_INT_1V024: begin
        next_internal_reference_enable = 1'b1;
      end
      `DSD_REF_INT_2V048: begin
        next_internal_reference_enable = 1'b1;
        next_internal_reference_2v048 = 1'b1;
      end
      `DSD_REF_EXTERNAL_LO, `DSD_REF_EXTERNAL_HI: begin
        // both codes leave the pin to an outside source
        next_internal_reference_enable = 1'b0;
      end
      default: begin
        next_internal_reference_enable = 1'b0;
      end
    endcase
  end

  // reference select is only touched by select 11 words; fast settle and power down follow every word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= dsd_pkg::DSD_ST_IDLE;
      cmd <= '0;
      ctrl <= '0;
      channel_a_value <= `DSD_VALUE_RESET;
      channel_b_value <= `DSD_VALUE_RESET;
      holding_value <= `DSD_VALUE_RESET;
      internal_reference_enable <= 1'b0;
      internal_reference_2v048 <= 1'b0;
      word_applied <= 1'b0;
      frame_used <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      ctrl <= next_ctrl;
      channel_a_value <= next_channel_a_value;
      channel_b_value <= next_channel_b_value;
      holding_value <= next_holding_value;
      internal_reference_enable <= next_internal_reference_enable;
      internal_reference_2v048 <= next_internal_reference_2v048;
      word_applied <= next_word_applied;
      frame_used <= next_frame_used;
    end
  end

  // ****************************************************************
  // setting outputs
  // ****************************************************************
  // copies keep each output on its own flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_settle_select <= 1'b0;
      power_down_request <= 1'b0;
      reference_select_high <= 1'b0;
      reference_select_low <= 1'b0;
    end else begin
      fast_settle_select <= next_ctrl.fast_settle_select;
      power_down_request <= next_ctrl.power_down_request;
      reference_select_high <= next_ctrl.reference_select_high;
      reference_select_low <= next_ctrl.reference_select_low;
    end
  end

endmodule // dsd_word_decoder

`default_nettype wire

// ==== dsd_word_decoder_assertions.sv ====
// concurrent checks on the serial word decoder ports
`timescale 1ns/100ps
`default_nettype none

module dsd_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdin,
  input wire logic [9:0] channel_a_value,
  input wire logic [9:0] channel_b_value,
  input wire logic [9:0] holding_value,
  input wire logic fast_settle_select,
  input wire logic power_down_request,
  input wire logic reference_select_high,
  input wire logic reference_select_low,
  input wire logic internal_reference_enable,
  input wire logic internal_reference_2v048,
  input wire logic word_applied
);
  // ****************************************************************
  // cycles since chip select was last seen low
  // ****************************************************************
  logic [5:0] idle_cnt;
  logic [5:0] next_idle_cnt;
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (!cs_n) begin
      next_idle_cnt = 6'h00;
    end else if (idle_cnt != 6'h3F) begin
      next_idle_cnt = idle_cnt + 6'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 6'h3F;
    end else begin
      idle_cnt <= next_idle_cnt;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  AST_INT_EN: assert property (internal_reference_enable == (reference_select_high ^ reference_select_low))
    else $error("internal reference enable wrong");
  AST_INT_2V: assert property (internal_reference_2v048 == (reference_select_high && !reference_select_low))
    else $error("internal 2.048 select wrong");
  AST_ONE_PULSE: assert property (word_applied |=> !word_applied)
    else $error("apply pulse longer than one cycle");
  AST_VAL_HOLD: assert property (!word_applied |-> $stable({channel_a_value, channel_b_value, holding_value}))
    else $error("value changed without a word");
  AST_CTRL_HOLD: assert property (!word_applied |-> $stable({fast_settle_select, power_down_request}))
    else $error("speed or power changed without a word");
  AST_A_WITH_B: assert property (word_applied && $changed(channel_a_value)
    |-> channel_b_value == $past(holding_value) && $stable(holding_value))
    else $error("channel B not loaded from buffer with A");
  AST_BUF_B: assert property (word_applied && $changed(holding_value)
    |-> $stable(channel_a_value) && ($stable(channel_b_value) || channel_b_value == holding_value))
    else $error("buffer write disturbed a latch");
  AST_REF_ONLY: assert property (word_applied && $changed({reference_select_high, reference_select_low})
    |-> $stable({channel_a_value, channel_b_value, holding_value}))
    else $error("control write touched a value latch");
  AST_NEAR_FRAME: assert property (word_applied |-> idle_cnt < 6'h10)
    else $error("word applied far from any frame");
  AST_RESET_ZERO: assert property ($fell(rst) |-> {channel_a_value, channel_b_value, holding_value,
    fast_settle_select, power_down_request, reference_select_high, reference_select_low, word_applied} == '0)
    else $error("outputs not clear after reset");
endmodule // dsd_chk

bind dsd_word_decoder dsd_chk chk_u (.clk, .rst, .sclk, .cs_n, .sdin, .channel_a_value, .channel_b_value,
  .holding_value, .fast_settle_select, .power_down_request, .reference_select_high, .reference_select_low,
  .internal_reference_enable, .internal_reference_2v048, .word_applied);

`default_nettype wire

// ==== dsd_host_model.sv ====
// behavioural host that shifts command words into the decoder
`timescale 1ns/100ps
`default_nettype none

module dsd_host_model (
  output var logic sclk,
  output var logic cs_n,
  output var logic sdin
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdin = 1'b0;
  end

  // ****************************************************************
  // one frame of n bits, msb first; stretch delays the first edge, bit period stays 48 ns
  // ****************************************************************
  task automatic send(input logic [31:0] data, input int n, input int stretch);
    cs_n = 1'b0;
    #(17.3 + stretch);
    for (int i = n - 1; i >= 0; i--) begin
      sdin = data[i];
      #24;
      sclk = 1'b0;
      #24;
      sclk = 1'b1;
    end
    #13;
    cs_n = 1'b1;
    // released line shows the inverse so a stale bit cannot pass for data
    sdin = ~sdin;
  endtask
endmodule // dsd_host_model

`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the serial word decoder
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk;
  logic rst;
  wire logic sclk;
  wire logic cs_n;
  wire logic sdin;
  logic [9:0] channel_a_value, channel_b_value, holding_value;
  logic fast_settle_select, power_down_request, reference_select_high, reference_select_low;
  logic internal_reference_enable, internal_reference_2v048, word_applied;
  logic [9:0] ea, eb, eh;
  logic ef, ep;
  logic [1:0] er;
  logic [15:0] sr;
  int fails, n_compared, seed;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  dsd_word_decoder dut_u (.clk, .rst, .sclk, .cs_n, .sdin, .channel_a_value, .channel_b_value,
    .holding_value, .fast_settle_select, .power_down_request, .reference_select_high, .reference_select_low,
    .internal_reference_enable, .internal_reference_2v048, .word_applied);
  dsd_host_model host_u (.sclk, .cs_n, .sdin);

  // ****************************************************************
  // checking and expectation helpers
  // ****************************************************************
  task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wrap_up;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // a short frame keeps older bits above; bits past sixteen are dropped
  function automatic logic [15:0] shift_in(logic [15:0] s, logic [31:0] d, int n);
    for (int i = n - 1; i >= 0; i--) if (n - 1 - i < 16) s = {s[14:0], d[i]};
    return s;
  endfunction

  task model_reset;
    {ea, eb, eh, ef, ep, er, sr} = '0;
  endtask

  task check_all;
    chk("chan_a", channel_a_value, ea);
    chk("chan_b", channel_b_value, eb);
    chk("holding", holding_value, eh);
    chk("fast", 10'(fast_settle_select), 10'(ef));
    chk("power", 10'(power_down_request), 10'(ep));
    chk("ref", 10'({reference_select_high, reference_select_low}), 10'(er));
    chk("int_ref", 10'({internal_reference_enable, internal_reference_2v048}), 10'({^er, er == 2'h2}));
  endtask

  task automatic frame(input logic [31:0] d, input int n);
    logic [15:0] w;
    logic got;
    got = 1'b0;
    fork
      host_u.send(d, n, {$random(seed)} % 8);
      for (int k = 0; k < 400 && !got; k++) begin
        @(negedge clk);
        got = (word_applied === 1'b1);
      end
    join
    chk("applied", 10'(got), 10'(n > 0));
    if (n > 0) begin
      sr = shift_in(sr, d, n);
      w = sr;
      ef = w[14];
      ep = w[13];
      case ({w[15], w[12]})
        2'h0: {eb, eh} = {w[11:2], w[11:2]};
        2'h1: eh = w[11:2];
        2'h2: {ea, eb} = {w[11:2], eh};
        default: er = w[1:0];
      endcase
    end
    check_all;
    repeat (10) @(posedge clk);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 96;
    fails = 0;
    n_compared = 0;
    rst = 1'b1;
    model_reset;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check_all;
    for (int r = 0; r < 4; r++) frame({16'h0, 4'hD, 10'($random(seed)), r[1:0]}, 16);
    frame({16'h0, 4'h4, 12'hAB7}, 16);
    frame({16'h0, 4'h1, 12'h5C3}, 16);
    frame({16'h0, 4'h8, 12'h3FC}, 16);
    frame({16'h0, 4'hA, 12'h000}, 16);
    frame(32'h000C_2345, 20);
    frame(32'h0000_0055, 8);
    frame(32'h0, 0);
    for (int r = 0; r < 40; r++) frame($random(seed), 16);
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    model_reset;
    repeat (3) @(posedge clk);
    check_all;
    frame($random(seed), 16);
    wrap_up;
  end

  initial begin
    #200000;
    fails++;
    wrap_up;
  end
endmodule // testbench

`default_nettype wire
